// >>> common/nand_host_pkg.sv
`default_nettype none
package nand_host_pkg;

   // ************************************************************
   // Clock and bus timing
   // ************************************************************
   localparam int CLK_PERIOD_NS   = 20;
   localparam int GLITCH_NS       = 5;
   localparam int SETUP_NS        = 20;
   localparam int STROBE_LOW_NS   = 25;
   localparam int STROBE_HIGH_NS  = 15;
   localparam int READ_ACCESS_NS  = 35;
   localparam int SYNC_STAGES     = 2;

   // Least times round up to whole cycles, and never below one.
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOW_CYC_RAW =
      (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GLITCH_CYC =
      (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOW_CYC = (LOW_CYC_RAW > GLITCH_CYC) ? LOW_CYC_RAW
                                                         : GLITCH_CYC;
   localparam int HIGH_CYC =
      (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_CYC =
      (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;

   localparam logic [7:0] SETUP_CNT = 8'((SETUP_CYC > 0) ? SETUP_CYC : 1);
   localparam logic [7:0] LOW_CNT   = 8'((LOW_CYC > 0) ? LOW_CYC : 1);
   localparam logic [7:0] HIGH_CNT  = 8'((HIGH_CYC > 0) ? HIGH_CYC : 1);
   localparam logic [7:0] READ_CNT  = 8'(READ_CYC);

   // ************************************************************
   // Address layout
   // ************************************************************
   localparam int ADDR_W = 29;
   localparam logic [2:0] CYCLES_SHORT = 3'h4;
   localparam logic [2:0] CYCLES_LONG  = 3'h5;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [2:0] {
      OP_CMD      = 3'h0,
      OP_ADDR     = 3'h1,
      OP_WRITE    = 3'h2,
      OP_READ     = 3'h3,
      OP_DESELECT = 3'h4
   } op_type;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_SETUP = 5'h02,
      ST_LOW   = 5'h04,
      ST_HIGH  = 5'h08,
      ST_DESEL = 5'h10
   } state_type;

   typedef struct packed {
      op_type              op;
      logic [15:0]         data;
      logic [ADDR_W-1:0]   addr;
   } request_type;

   typedef struct packed {
      logic        chip_sel_n;
      logic        cmd_latch_strobe;
      logic        addr_latch_strobe;
      logic        write_n;
      logic        read_n;
      logic        write_prot_n;
      logic [15:0] io_out;
      logic        io_oe;
   } pins_type;

   localparam pins_type PINS_IDLE = '{
      chip_sel_n:        1'b1,
      cmd_latch_strobe:  1'b0,
      addr_latch_strobe: 1'b0,
      write_n:           1'b1,
      read_n:            1'b1,
      write_prot_n:      1'b0,
      io_out:            16'h0000,
      io_oe:             1'b0
   };

endpackage
`default_nettype wire

// >>> rtl/sync_two_flop.sv
`default_nettype none
module sync_two_flop #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output var  logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_reg;

   // ************************************************************
   // Two stages; only the second stage is read.
   // ************************************************************
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         meta_reg <= '0;
         sync_o   <= '0;
      end else begin
         meta_reg <= async_i;
         sync_o   <= meta_reg;
      end
   end

endmodule
`default_nettype wire

// >>> rtl/nand_host_ctrl.sv
`default_nettype none
module nand_host_ctrl #(
   parameter bit WIDE16     = 1'b0,
   parameter bit FIVE_CYCLE = 1'b1
) (
   input  wire logic                      clock_i,
   input  wire logic                      rst_i,
   input  wire logic                      req_valid_i,
   input  wire nand_host_pkg::request_type req_i,
   output var  logic                      req_ready_o,
   output var  logic                      rsp_valid_o,
   output var  logic [15:0]               rsp_data_o,
   input  wire logic                      prot_release_i,
   input  wire logic                      supply_ok_i,
   input  wire logic                      ready_busy_n_i,
   input  wire logic [15:0]               io_i,
   output var  nand_host_pkg::pins_type   pins_o,
   output var  logic                      device_ready_o
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      nand_host_pkg::state_type st;
      logic [7:0]               cnt;
      logic [2:0]               idx;
      nand_host_pkg::op_type    op;
      logic [15:0]              data;
      logic [nand_host_pkg::ADDR_W-1:0] addr;
      nand_host_pkg::pins_type  pins;
      logic                     ready;
      logic                     rsp_valid;
      logic [15:0]              rsp_data;
      logic                     dev_ready;
   } ctrl_type;

   ctrl_type ctrl_reg;
   ctrl_type ctrl_next;

   logic [15:0] io_sync;
   logic        rb_sync;
   logic        supply_sync;
   logic [2:0]  last_idx;

   // The address phase length follows the array density.
   assign last_idx = FIVE_CYCLE
      ? 3'(nand_host_pkg::CYCLES_LONG - 3'h1)
      : 3'(nand_host_pkg::CYCLES_SHORT - 3'h1);

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   sync_two_flop #(
      .WIDTH (18)
   ) u_sync (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .async_i ({io_i, ready_busy_n_i, supply_ok_i}),
      .sync_o  ({io_sync, rb_sync, supply_sync})
   );

   // ************************************************************
   // Address byte selection
   // ************************************************************
   // Returns the low-byte value for one address cycle.
   function automatic logic [7:0] addr_byte(
      input logic [2:0]                      idx,
      input logic [nand_host_pkg::ADDR_W-1:0] a
   );
      logic [7:0] b;
      b = 8'h00;
      if (WIDE16) begin
         case (idx)
            3'h0:    b = a[7:0];
            3'h1:    b = {5'h00, a[10:8]};
            3'h2:    b = a[18:11];
            3'h3:    b = a[26:19];
            default: b = {7'h00, a[27]};
         endcase
      end else begin
         case (idx)
            3'h0:    b = a[7:0];
            3'h1:    b = {4'h0, a[11:8]};
            3'h2:    b = a[19:12];
            3'h3:    b = a[27:20];
            default: b = {7'h00, a[28]};
         endcase
      end
      return b;
   endfunction

   // ************************************************************
   // Next state
   // ************************************************************
   // One bus cycle per request; an address request runs all cycles.
   always_comb begin
      ctrl_next = ctrl_reg;
      ctrl_next.rsp_valid = 1'b0;
      ctrl_next.dev_ready = rb_sync;
      // Protect is released only on request and with supply good.
      ctrl_next.pins.write_prot_n = prot_release_i & supply_sync;
      case (ctrl_reg.st)
         nand_host_pkg::ST_IDLE: begin
            ctrl_next.ready = 1'b1;
            if (req_valid_i && ctrl_reg.ready && supply_sync) begin
               ctrl_next.ready = 1'b0;
               ctrl_next.op    = req_i.op;
               ctrl_next.data  = req_i.data;
               ctrl_next.addr  = req_i.addr;
               ctrl_next.idx   = 3'h0;
               ctrl_next.cnt   = nand_host_pkg::SETUP_CNT - 8'h01;
               ctrl_next.pins.write_n = 1'b1;
               ctrl_next.pins.read_n  = 1'b1;
               ctrl_next.st = nand_host_pkg::ST_SETUP;
               case (req_i.op)
                  nand_host_pkg::OP_CMD: begin
                     ctrl_next.pins.chip_sel_n        = 1'b0;
                     ctrl_next.pins.cmd_latch_strobe  = 1'b1;
                     ctrl_next.pins.addr_latch_strobe = 1'b0;
                     ctrl_next.pins.io_out = {8'h00, req_i.data[7:0]};
                     ctrl_next.pins.io_oe  = 1'b1;
                  end
                  nand_host_pkg::OP_ADDR: begin
                     ctrl_next.pins.chip_sel_n        = 1'b0;
                     ctrl_next.pins.cmd_latch_strobe  = 1'b0;
                     ctrl_next.pins.addr_latch_strobe = 1'b1;
                     ctrl_next.pins.io_out =
                        {8'h00, addr_byte(3'h0, req_i.addr)};
                     ctrl_next.pins.io_oe  = 1'b1;
                  end
                  nand_host_pkg::OP_WRITE: begin
                     ctrl_next.pins.chip_sel_n        = 1'b0;
                     ctrl_next.pins.cmd_latch_strobe  = 1'b0;
                     ctrl_next.pins.addr_latch_strobe = 1'b0;
                     ctrl_next.pins.io_out = WIDE16 ? req_i.data
                                           : {8'h00, req_i.data[7:0]};
                     ctrl_next.pins.io_oe  = 1'b1;
                  end
                  nand_host_pkg::OP_READ: begin
                     ctrl_next.pins.chip_sel_n        = 1'b0;
                     ctrl_next.pins.cmd_latch_strobe  = 1'b0;
                     ctrl_next.pins.addr_latch_strobe = 1'b0;
                     ctrl_next.pins.io_oe  = 1'b0;
                  end
                  default: begin
                     // Deselect waits for the device to go ready first.
                     ctrl_next.pins.cmd_latch_strobe  = 1'b0;
                     ctrl_next.pins.addr_latch_strobe = 1'b0;
                     ctrl_next.pins.io_oe = 1'b0;
                     ctrl_next.st = nand_host_pkg::ST_DESEL;
                  end
               endcase
            end
         end
         nand_host_pkg::ST_SETUP: begin
            if (ctrl_reg.cnt == 8'h00) begin
               ctrl_next.st = nand_host_pkg::ST_LOW;
               if (ctrl_reg.op == nand_host_pkg::OP_READ) begin
                  ctrl_next.pins.read_n = 1'b0;
                  ctrl_next.cnt = nand_host_pkg::READ_CNT - 8'h01;
               end else begin
                  ctrl_next.pins.write_n = 1'b0;
                  ctrl_next.cnt = nand_host_pkg::LOW_CNT - 8'h01;
               end
            end else begin
               ctrl_next.cnt = ctrl_reg.cnt - 8'h01;
            end
         end
         nand_host_pkg::ST_LOW: begin
            if (ctrl_reg.cnt == 8'h00) begin
               // The rising write strobe latches; data stays for hold.
               ctrl_next.pins.write_n = 1'b1;
               ctrl_next.pins.read_n  = 1'b1;
               if (ctrl_reg.op == nand_host_pkg::OP_READ) begin
                  // Any output kind arrives here alike.
                  ctrl_next.rsp_data = WIDE16 ? io_sync
                                     : {8'h00, io_sync[7:0]};
               end
               ctrl_next.cnt = nand_host_pkg::HIGH_CNT - 8'h01;
               ctrl_next.st  = nand_host_pkg::ST_HIGH;
            end else begin
               ctrl_next.cnt = ctrl_reg.cnt - 8'h01;
            end
         end
         nand_host_pkg::ST_HIGH: begin
            if (ctrl_reg.cnt != 8'h00) begin
               ctrl_next.cnt = ctrl_reg.cnt - 8'h01;
            end else if (ctrl_reg.op == nand_host_pkg::OP_ADDR &&
                         ctrl_reg.idx != last_idx) begin
               // Next address cycle; never more than the density needs.
               ctrl_next.idx = ctrl_reg.idx + 3'h1;
               ctrl_next.pins.io_out =
                  {8'h00, addr_byte(3'(ctrl_reg.idx + 3'h1),
                                    ctrl_reg.addr)};
               ctrl_next.pins.write_n = 1'b0;
               ctrl_next.cnt = nand_host_pkg::LOW_CNT - 8'h01;
               ctrl_next.st  = nand_host_pkg::ST_LOW;
            end else begin
               ctrl_next.pins.cmd_latch_strobe  = 1'b0;
               ctrl_next.pins.addr_latch_strobe = 1'b0;
               ctrl_next.pins.io_oe = 1'b0;
               ctrl_next.rsp_valid  = 1'b1;
               ctrl_next.ready      = 1'b1;
               ctrl_next.st = nand_host_pkg::ST_IDLE;
            end
         end
         nand_host_pkg::ST_DESEL: begin
            // Chip select rises only once the device is ready.
            if (rb_sync) begin
               ctrl_next.pins.chip_sel_n = 1'b1;
               ctrl_next.pins.io_oe      = 1'b0;
               ctrl_next.rsp_valid = 1'b1;
               ctrl_next.ready     = 1'b1;
               ctrl_next.st = nand_host_pkg::ST_IDLE;
            end
         end
         default: begin
            ctrl_next.st = nand_host_pkg::ST_IDLE;
         end
      endcase
      // Supply lockout aborts everything and leaves the bus idle.
      if (!supply_sync) begin
         ctrl_next.pins      = nand_host_pkg::PINS_IDLE;
         ctrl_next.ready     = 1'b0;
         ctrl_next.rsp_valid = 1'b0;
         ctrl_next.st        = nand_host_pkg::ST_IDLE;
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         ctrl_reg.st        <= nand_host_pkg::ST_IDLE;
         ctrl_reg.cnt       <= 8'h00;
         ctrl_reg.idx       <= 3'h0;
         ctrl_reg.op        <= nand_host_pkg::OP_CMD;
         ctrl_reg.data      <= 16'h0000;
         ctrl_reg.addr      <= '0;
         ctrl_reg.pins      <= nand_host_pkg::PINS_IDLE;
         ctrl_reg.ready     <= 1'b0;
         ctrl_reg.rsp_valid <= 1'b0;
         ctrl_reg.rsp_data  <= 16'h0000;
         ctrl_reg.dev_ready <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign req_ready_o    = ctrl_reg.ready;
   assign rsp_valid_o    = ctrl_reg.rsp_valid;
   assign rsp_data_o     = ctrl_reg.rsp_data;
   assign pins_o         = ctrl_reg.pins;
   assign device_ready_o = ctrl_reg.dev_ready;

endmodule
`default_nettype wire

// >>> testbench/nand_host_checker.sv
`default_nettype none
module nand_host_checker (
   input wire logic                       clock_i,
   input wire logic                       rst_i,
   input wire logic                       req_valid_i,
   input wire nand_host_pkg::request_type req_i,
   input wire logic                       req_ready_o,
   input wire logic                       rsp_valid_o,
   input wire logic [15:0]                rsp_data_o,
   input wire logic                       prot_release_i,
   input wire logic                       supply_ok_i,
   input wire logic                       ready_busy_n_i,
   input wire logic [15:0]                io_i,
   input wire nand_host_pkg::pins_type    pins_o,
   input wire logic                       device_ready_o
);
   // ************************************************************
   // Strobe and pin relations
   // ************************************************************
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   AST_CMD_CYCLE: assert property (pins_o.cmd_latch_strobe |->
      !pins_o.addr_latch_strobe && !pins_o.chip_sel_n && pins_o.read_n)
      else $error("command latch outside a command cycle");
   AST_ADDR_CYCLE: assert property (pins_o.addr_latch_strobe |->
      !pins_o.cmd_latch_strobe && !pins_o.chip_sel_n && pins_o.read_n)
      else $error("address latch outside an address cycle");
   AST_WRITE_EDGE: assert property ($rose(pins_o.write_n)
      && !pins_o.chip_sel_n |-> pins_o.read_n && pins_o.io_oe
      && $stable(pins_o.io_out))
      else $error("write strobe rose on a bad cycle");
   AST_READ_CYCLE: assert property (!pins_o.read_n |->
      pins_o.write_n && !pins_o.cmd_latch_strobe
      && !pins_o.addr_latch_strobe && !pins_o.chip_sel_n)
      else $error("read strobe low on a bad cycle");
   AST_IO_RELEASE: assert property (!pins_o.read_n
      || pins_o.chip_sel_n |-> !pins_o.io_oe)
      else $error("host drives io while device owns it");
   // A lockout abort may cut a strobe, but only together with deselect.
   AST_WRITE_WIDTH: assert property ($fell(pins_o.write_n) |=>
      !pins_o.write_n || pins_o.chip_sel_n)
      else $error("write strobe pulse too short");
   AST_READ_WIDTH: assert property ($fell(pins_o.read_n) |=>
      !pins_o.read_n || pins_o.chip_sel_n)
      else $error("read strobe pulse too short");
   AST_LOCKOUT: assert property (!supply_ok_i [*5] |->
      pins_o.chip_sel_n && pins_o.write_n && pins_o.read_n
      && !pins_o.write_prot_n && !req_ready_o)
      else $error("bus active during supply lockout");
   // A deselect without a response is an abort and leaves the bus idle.
   AST_ABORT_IDLE: assert property ($rose(pins_o.chip_sel_n)
      && !rsp_valid_o |-> pins_o.write_n && pins_o.read_n
      && !pins_o.io_oe && !pins_o.write_prot_n)
      else $error("abort left the bus active");
   AST_PROTECT: assert property (!prot_release_i [*5] |->
      !pins_o.write_prot_n)
      else $error("protect released without permission");
   AST_DESELECT: assert property ($rose(pins_o.chip_sel_n)
      && rsp_valid_o |-> $past(ready_busy_n_i, 2))
      else $error("deselected while device busy");
   AST_RSP_PULSE: assert property (rsp_valid_o |->
      req_ready_o ##1 !rsp_valid_o)
      else $error("response not a single pulse");
   // Main scenarios: command, read, deselect.
   COV_CMD: cover property ($rose(pins_o.write_n) && pins_o.cmd_latch_strobe);
   COV_READ: cover property ($rose(pins_o.read_n));
   COV_DESEL: cover property ($rose(pins_o.chip_sel_n) && rsp_valid_o);
endmodule
bind nand_host_ctrl nand_host_checker u_nand_host_checker (
   .clock_i(clock_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
   .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
   .rsp_data_o(rsp_data_o), .prot_release_i(prot_release_i),
   .supply_ok_i(supply_ok_i), .ready_busy_n_i(ready_busy_n_i),
   .io_i(io_i), .pins_o(pins_o), .device_ready_o(device_ready_o));
`default_nettype wire

// >>> testbench/nand_dev_model.sv
`default_nettype none
module nand_dev_model (
   input  wire logic                    clock_i,
   input  wire logic                    supply_ok_i,
   input  wire nand_host_pkg::pins_type pins_i,
   input  wire logic [15:0]             io_i,
   output var  logic [15:0]             io_o,
   output var  logic                    rb_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // Byte-wide device with five address cycles
   // ************************************************************
   logic [7:0]  last_cmd = 8'h00;
   logic [7:0]  abytes [0:4];
   logic [15:0] wdata [$];
   logic [11:0] col = 12'h000;
   logic [11:0] col_addr;
   logic [5:0]  page_addr;
   logic [10:0] block_addr;
   int          acount = 0;
   int          prog_count = 0;
   int          busy = 0;
   // Fields of the captured address, byte-wide layout.
   assign col_addr = {abytes[1][3:0], abytes[0]};
   assign page_addr = abytes[2][5:0];
   assign block_addr = {abytes[4][0], abytes[3], abytes[2][7:6]};
   assign rb_n_o = (busy == 0);
   // Captures on the rising write strobe, only with the supply good.
   always @(posedge pins_i.write_n) begin
      if (supply_ok_i && !pins_i.chip_sel_n && pins_i.read_n) begin
         if (pins_i.cmd_latch_strobe && !pins_i.addr_latch_strobe) begin
            last_cmd = io_i[7:0];
            acount = 0;
            col = col_addr;
            if (last_cmd == 8'h80) wdata.delete();
            if (last_cmd == 8'h30) busy = 6;
            if (last_cmd == 8'h10 &&
                pins_i.write_prot_n) begin
               prog_count++;
               busy = 6;
            end
         end else if (pins_i.addr_latch_strobe && !pins_i.cmd_latch_strobe) begin
            if (acount < 5) abytes[acount] = io_i[7:0];
            acount++;
         end else if (!pins_i.addr_latch_strobe && !pins_i.cmd_latch_strobe) begin
            wdata.push_back(io_i);
         end
      end
   end
   // Busy time runs down on the clock; deselect does not cut it short.
   always @(posedge clock_i) begin
      if (busy > 0) busy <= busy - 1;
   end
   // One word per falling read strobe, then the column advances.
   always @(negedge pins_i.read_n) begin
      if (!pins_i.chip_sel_n && pins_i.write_n && rb_n_o
          && !pins_i.cmd_latch_strobe && !pins_i.addr_latch_strobe) begin
         io_o = (last_cmd == 8'h70) ? 16'h00E0
                                    : {8'h00, col[7:0] ^ 8'h5A};
         col = col + 12'h001;
      end
   end
   // Each release of read strobe or chip select inverts the lines, so a second release brings back the last value.
   always @(posedge pins_i.read_n or posedge pins_i.chip_sel_n) begin
      io_o = ~io_o;
   end
   initial io_o = 16'h5A5A;
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // Clock, reset and instances
   // ************************************************************
   logic                       clock_i = 1'b0;
   logic                       rst_i = 1'b1;
   logic                       req_valid_i = 1'b0;
   logic                       prot_release_i = 1'b0;
   logic                       supply_ok_i = 1'b1;
   nand_host_pkg::request_type req_i = '0;
   logic                       req_ready_o;
   logic                       rsp_valid_o;
   logic                       device_ready_o;
   logic                       rb_n;
   logic [15:0]                rsp_data_o;
   logic [15:0]                dev_io;
   logic [15:0]                io_bus;
   nand_host_pkg::pins_type    pins_o;
   int                         errors = 0;
   int                         checked = 0;
   int                         rsp_cnt = 0;
   // The clock toggles every half period of 20 ns.
   always #10 clock_i = ~clock_i;
   // Responses are counted so a missing one can be seen.
   always @(posedge clock_i) if (rsp_valid_o === 1'b1) rsp_cnt++;
   // Whoever enables the io lines sets their level.
   assign io_bus = pins_o.io_oe ? pins_o.io_out : dev_io;
   nand_host_ctrl u_nand_host_ctrl (.clock_i(clock_i), .rst_i(rst_i),
      .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
      .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
      .prot_release_i(prot_release_i), .supply_ok_i(supply_ok_i),
      .ready_busy_n_i(rb_n), .io_i(io_bus), .pins_o(pins_o),
      .device_ready_o(device_ready_o));
   nand_dev_model u_nand_dev_model (.clock_i(clock_i),
      .supply_ok_i(supply_ok_i), .pins_i(pins_o), .io_i(io_bus),
      .io_o(dev_io), .rb_n_o(rb_n));
   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic hang;
      errors++;
      print_verdict;
   endtask
   task automatic issue(input nand_host_pkg::op_type op, input logic [15:0] d,
                        input logic [28:0] a);
      int n;
      n = 0;
      while (req_ready_o !== 1'b1) begin
         @(negedge clock_i);
         n++;
         if (n > 300) hang;
      end
      req_valid_i = 1'b1;
      req_i = '{op: op, data: d, addr: a};
      @(negedge clock_i);
      req_valid_i = 1'b0;
   endtask
   task automatic do_req(input nand_host_pkg::op_type op, input logic [15:0] d,
                         input logic [28:0] a);
      int n;
      int r0;
      n = 0;
      r0 = rsp_cnt;
      issue(op, d, a);
      while (rsp_cnt == r0) begin
         @(negedge clock_i);
         n++;
         if (n > 300) hang;
      end
   endtask
   task automatic wait_dev(input logic lvl);
      int n;
      n = 0;
      while (device_ready_o !== lvl) begin
         @(negedge clock_i);
         n++;
         if (n > 100) hang;
      end
   endtask
   // Sends a command with junk on the high byte, then a full address.
   task automatic cmd_addr(input logic [7:0] c, input logic [28:0] a);
      logic [7:0] exp [0:4];
      exp = '{a[7:0], {4'h0, a[11:8]}, a[19:12], a[27:20], {7'h00, a[28]}};
      do_req(nand_host_pkg::OP_CMD, {8'hC3, c}, a);
      check(u_nand_dev_model.last_cmd, c);
      do_req(nand_host_pkg::OP_ADDR, 16'h0000, a);
      check(u_nand_dev_model.acount, 5);
      for (int i = 0; i < 5; i++)
         check(u_nand_dev_model.abytes[i], exp[i]);
      check(u_nand_dev_model.col_addr, a[11:0]);
      check(u_nand_dev_model.page_addr, a[17:12]);
      check(u_nand_dev_model.block_addr, a[28:18]);
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_read;
      cmd_addr(8'h00, 29'h1ABC_D7FE);
      do_req(nand_host_pkg::OP_CMD, 16'h0030, '0);
      wait_dev(1'b0);
      wait_dev(1'b1);
      for (int i = 0; i < 3; i++) begin
         do_req(nand_host_pkg::OP_READ, 16'h0000, '0);
         check(rsp_data_o, {8'h00, 8'(12'h7FE + i) ^ 8'h5A});
      end
      do_req(nand_host_pkg::OP_CMD, 16'h0070, '0);
      do_req(nand_host_pkg::OP_READ, 16'h0000, '0);
      check(rsp_data_o, 16'h00E0);
      $display("read test done");
   endtask
   task automatic t_program(input logic prot, input int inc);
      int p0;
      prot_release_i = prot;
      repeat (5) @(negedge clock_i);
      p0 = u_nand_dev_model.prog_count;
      cmd_addr(8'h80, 29'h0000_0FFF);
      do_req(nand_host_pkg::OP_WRITE, 16'h00A5, '0);
      do_req(nand_host_pkg::OP_WRITE, 16'h003C, '0);
      do_req(nand_host_pkg::OP_CMD, 16'h0010, '0);
      repeat (12) @(negedge clock_i);
      check(u_nand_dev_model.prog_count, p0 + inc);
      check(u_nand_dev_model.wdata[0], 16'h00A5);
      check(u_nand_dev_model.wdata[1], 16'h003C);
      $display("program test done");
   endtask
   task automatic t_deselect;
      cmd_addr(8'h00, 29'h0012_3456);
      do_req(nand_host_pkg::OP_CMD, 16'h0030, '0);
      do_req(nand_host_pkg::OP_DESELECT, 16'h0000, '0);
      check(u_nand_dev_model.rb_n_o, 1'b1);
      check({pins_o.chip_sel_n, pins_o.io_oe}, 2'b10);
      $display("deselect test done");
   endtask
   task automatic t_lockout;
      int r0;
      r0 = rsp_cnt;
      do_req(nand_host_pkg::OP_CMD, 16'h0000, '0);
      issue(nand_host_pkg::OP_ADDR, 16'h0000, 29'h1FFF_FFFF);
      repeat (5) @(negedge clock_i);
      supply_ok_i = 1'b0;
      repeat (8) @(negedge clock_i);
      check(rsp_cnt, r0 + 1);
      check({pins_o.chip_sel_n, req_ready_o}, 2'b10);
      check(u_nand_dev_model.acount < 5, 1);
      supply_ok_i = 1'b1;
      repeat (6) @(negedge clock_i);
      $display("lockout test done");
   endtask
   // Main sequence: reset, then every scenario, then the verdict.
   initial begin
      repeat (4) @(negedge clock_i);
      check(32'(pins_o), 32'(nand_host_pkg::PINS_IDLE));
      rst_i = 1'b0;
      cmd_addr(8'h00, 29'h1ABC_DEF1);
      t_read;
      t_program(1'b1, 1);
      t_program(1'b0, 0);
      t_deselect;
      t_lockout;
      print_verdict;
   end
endmodule
`default_nettype wire
